// ### core/pds_power_down_seq.sv
`timescale 1ns/1ns
`include "pds_defines.svh"

// Contract
// - Enter power-down: both enables low, one fell.
// - Command with enable drop forwarded, enables low.
// - Keep bit selects termination off or on.
// - Termination-off: receivers, termination off after delay.
// - Parity receiver lingers one clock longer.
// - Termination-off: termination and enable outputs low.
// - Other outputs float after output-disable delay.
// - Exit: enable follows, fixed outputs, then follow.
// - Termination-off exit: selects high, termination low.
// - Termination-on exit: selects high, termination follows.
// - Termination-on: termination and its receivers stay.
// - Selects held high one clock on exit.
// - Clock stopped: PLL off, float, enables low.
// - Outputs track inputs within activation time.
module pds_power_down_seq
    import pds_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Configuration
    input  wire logic                  power_down_enable_bit,
    input  wire logic                  termination_keep_bit,
    input  wire logic                  four_select_mode,
    // Controller side
    input  wire logic [`PDS_CKE_W-1:0] clock_enable_in,
    input  wire logic [`PDS_CS_W-1:0]  chip_select_in_n,
    input  wire logic [`PDS_ODT_W-1:0] termination_ctrl_in,
    input  wire logic [`PDS_AC_W-1:0]  addr_cmd_in,
    input  wire logic                  clocks_stopped,
    // Memory side
    output logic      [`PDS_CKE_W-1:0] clock_enable_out,
    output logic      [`PDS_CS_W-1:0]  chip_select_out_n,
    output logic                       chip_select_oe_n,
    output logic      [`PDS_ODT_W-1:0] termination_ctrl_out,
    output logic                       termination_oe_n,
    output logic      [`PDS_AC_W-1:0]  address_out,
    output logic                       address_oe_n,
    // Receiver and clock control
    output logic                       addr_rx_en,
    output logic                       parity_rx_en,
    output logic                       termination_rx_en,
    output logic                       input_termination_en,
    output logic                       pll_run
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // In two-select mode the upper selects do not exist and read as deasserted.
    function automatic logic [`PDS_CS_W-1:0] cs_mask(input logic [`PDS_CS_W-1:0] cs, input logic quad);
        cs_mask = quad ? cs : {`PDS_TWO_SEL_MASK, cs[1:0]};
    endfunction

    function automatic logic in_power_down(input pds_state_e st);
        in_power_down = (st == ST_ENTRY) || (st == ST_PDOWN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State and timers.

    pds_state_e                  state_q;
    pds_state_e                  state_d;
    logic       [`PDS_CKE_W-1:0] cke_q;
    logic                        keep_q;
    logic                        float_q;
    logic                        a_start;
    pds_count_t                  a_val;
    logic                        a_last;
    logic                        b_start;
    logic                        b_last;
    logic                        enter;
    logic                        wake_req;
    logic                        exit_edge;
    logic                        pd_d;
    logic                        float_d;

    assign wake_req  = |clock_enable_in;
    assign enter     = power_down_enable_bit && (clock_enable_in == 2'h0) && (cke_q != 2'h0);
    assign exit_edge = (state_d == ST_EXIT) && (state_q != ST_EXIT);
    assign pd_d      = in_power_down(state_d);
    assign float_d   = pd_d && (float_q || b_last);
    assign b_start   = (state_q == ST_NORMAL) && (state_d == ST_ENTRY);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cke_q <= `PDS_CKE_RST;
        end else begin
            cke_q <= clock_enable_in;
        end
    end

    always_comb begin
        state_d = state_q;
        a_start = 1'b0;
        a_val   = `PDS_IN_DIS_CLKS;
        case (state_q)
            ST_NORMAL: begin
                if (clocks_stopped) begin
                    state_d = ST_CKSTOP;
                end else if (enter) begin
                    state_d = ST_ENTRY;
                    a_start = 1'b1;
                end
            end
            ST_ENTRY, ST_PDOWN: begin
                if (clocks_stopped) begin
                    state_d = ST_CKSTOP;
                end else if (wake_req) begin
                    state_d = ST_EXIT;
                    a_start = 1'b1;
                    a_val   = `PDS_FIX_OUT_CLKS;
                end else if ((state_q == ST_ENTRY) && a_last) begin
                    state_d = ST_PDOWN;
                end
            end
            ST_EXIT: begin
                if (clocks_stopped) begin
                    state_d = ST_CKSTOP;
                end else if (a_last) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_CKSTOP: begin
                if (!clocks_stopped) begin
                    state_d = ST_WAKE;
                    a_start = 1'b1;
                    a_val   = 8'(`PDS_ACT_CLKS);
                end
            end
            ST_WAKE: begin
                if (a_last) begin
                    state_d = ST_NORMAL;
                end
            end
            default: begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // The variant is frozen at entry so a mid-sequence change of the bit cannot mix the two.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            keep_q <= 1'b0;
        end else if (b_start) begin
            keep_q <= termination_keep_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            float_q <= 1'b0;
        end else begin
            float_q <= float_d;
        end
    end

    // Timer a paces the input-disable, fixed-output and activation intervals in turn.
    pds_timer u_seq_timer (
        .clk      (clk),
        .rstn     (rstn),
        .start    (a_start),
        .load_val (a_val),
        .last     (a_last)
    );

    // Timer b runs the output-disable delay alongside, from the edge that drops the enables.
    pds_timer u_float_timer (
        .clk      (clk),
        .rstn     (rstn),
        .start    (b_start),
        .load_val (`PDS_Q_DIS_CLKS),
        .last     (b_last)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output registers.

    always_ff @(posedge clk) begin
        if (!rstn) begin
            clock_enable_out <= `PDS_CKE_RST;
        end else if ((state_d == ST_CKSTOP) || (pd_d && !wake_req)) begin
            clock_enable_out <= 2'h0;
        end else begin
            clock_enable_out <= clock_enable_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            chip_select_out_n <= `PDS_CS_IDLE;
        end else if (exit_edge || (pd_d && !b_start) || (state_d == ST_CKSTOP)) begin
            chip_select_out_n <= `PDS_CS_IDLE;
        end else begin
            chip_select_out_n <= cs_mask(chip_select_in_n, four_select_mode);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            termination_ctrl_out <= `PDS_ODT_RST;
        end else if (state_d == ST_CKSTOP) begin
            termination_ctrl_out <= `PDS_ODT_RST;
        end else if ((pd_d || (state_d == ST_EXIT)) && !keep_q) begin
            termination_ctrl_out <= `PDS_ODT_RST;
        end else begin
            termination_ctrl_out <= termination_ctrl_in;
        end
    end

    // Command and address hold their last level as the fixed exit pattern.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            address_out <= `PDS_AC_RST;
        end else if ((state_d == ST_NORMAL) || (state_d == ST_WAKE) || b_start) begin
            address_out <= addr_cmd_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            address_oe_n     <= 1'b1;
            chip_select_oe_n <= 1'b1;
            termination_oe_n <= 1'b1;
        end else begin
            address_oe_n     <= (state_d == ST_CKSTOP) || (state_d == ST_WAKE) || float_d;
            chip_select_oe_n <= (state_d == ST_CKSTOP) || (state_d == ST_WAKE) || float_d;
            termination_oe_n <= (state_d == ST_CKSTOP) || (state_d == ST_WAKE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver, termination and clock control.

    logic rx_d;

    assign rx_d = !((state_d == ST_PDOWN) || (state_d == ST_CKSTOP));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_rx_en   <= 1'b1;
            parity_rx_en <= 1'b1;
        end else begin
            addr_rx_en   <= rx_d;
            parity_rx_en <= rx_d || addr_rx_en;
        end
    end

    // Reset keeps termination off; the enable and clock receivers are never gated here.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            termination_rx_en    <= 1'b1;
            input_termination_en <= 1'b0;
        end else begin
            termination_rx_en    <= rx_d || keep_q;
            input_termination_en <= rx_d || ((state_d == ST_PDOWN) && keep_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pll_run <= 1'b1;
        end else begin
            pll_run <= (state_d != ST_CKSTOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    localparam int ACT_BOUND = `PDS_ACT_CLKS + 1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_entry_drop: assert property ((state_q == ST_NORMAL) && enter && !clocks_stopped
        |=> (state_q == ST_ENTRY) && (clock_enable_out == 2'h0))
        else $error("Power-down entry missed or enables not low.");

    a_cmd_forward: assert property ((state_q == ST_NORMAL) && enter && !clocks_stopped
        |=> chip_select_out_n == $past(cs_mask(chip_select_in_n, four_select_mode)))
        else $error("Command at enable drop not forwarded.");

    a_rx_off_state: assert property (!addr_rx_en |-> (state_q == ST_PDOWN) || (state_q == ST_CKSTOP))
        else $error("Receivers off outside power-down.");

    a_parity_lag: assert property ($fell(addr_rx_en) |-> parity_rx_en ##1 (parity_rx_en == addr_rx_en))
        else $error("Parity receiver did not linger one clock.");

    a_off_levels: assert property ((state_q == ST_PDOWN) && !keep_q
        |-> (termination_ctrl_out == 2'h0) && (clock_enable_out == 2'h0) && !input_termination_en)
        else $error("Termination-off power-down levels wrong.");

    a_float_delay: assert property ($rose(address_oe_n) && in_power_down(state_q) |-> $past(b_last))
        else $error("Outputs floated before output-disable delay.");

    a_exit_start: assert property (in_power_down(state_q) && wake_req && !clocks_stopped
        |=> (state_q == ST_EXIT) && (clock_enable_out == $past(clock_enable_in))
            && (chip_select_out_n == `PDS_CS_IDLE) && !address_oe_n)
        else $error("Exit did not start correctly.");

    a_fix_hold: assert property ((state_q == ST_EXIT) && $past(state_q == ST_EXIT)
        |-> address_out == $past(address_out))
        else $error("Fixed outputs changed during exit.");

    a_exit_off_odt: assert property ((state_q == ST_EXIT) && !keep_q |-> termination_ctrl_out == 2'h0)
        else $error("Termination output not low on exit.");

    a_exit_on_odt: assert property ((state_q == ST_EXIT) && keep_q && $past(state_q == ST_EXIT)
        |-> termination_ctrl_out == $past(termination_ctrl_in))
        else $error("Termination output not following on exit.");

    a_cs_one_clk: assert property ((state_q == ST_EXIT) && $past(state_q == ST_EXIT)
        |-> chip_select_out_n == $past(cs_mask(chip_select_in_n, four_select_mode)))
        else $error("Selects held high longer than one clock.");

    a_keep_rx: assert property ((state_q == ST_PDOWN) && keep_q
        |-> input_termination_en && termination_rx_en && !addr_rx_en)
        else $error("Termination-on power-down receivers wrong.");

    a_ckstop_out: assert property ((state_q == ST_CKSTOP)
        |-> (clock_enable_out == 2'h0) && address_oe_n && chip_select_oe_n && termination_oe_n && !pll_run)
        else $error("Clock-stopped outputs wrong.");

    a_wake_time: assert property ($rose(state_q == ST_WAKE) |-> ##[1:ACT_BOUND] (state_q == ST_NORMAL))
        else $error("Outputs not tracking within activation time.");

    a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
        !rstn |=> (state_q == ST_NORMAL) && (clock_enable_out == 2'h0))
        else $error("Reset did not return to normal.");

    c_off_cycle: cover property ((state_q == ST_PDOWN) && !keep_q ##[1:50] (state_q == ST_EXIT));
    c_on_cycle: cover property ((state_q == ST_PDOWN) && keep_q ##[1:50] (state_q == ST_NORMAL));
    c_clock_stop: cover property ((state_q == ST_CKSTOP) ##[1:50] (state_q == ST_WAKE));
    c_quick_exit: cover property ((state_q == ST_ENTRY) ##1 (state_q == ST_EXIT));

endmodule

// ### core/pds_defines.svh
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH

// Port widths.
`define PDS_CKE_W        2
`define PDS_CS_W         4
`define PDS_ODT_W        2
`define PDS_AC_W         22
`define PDS_TMR_W        8

// Clock rate and delays in clocks (input_disable_delay, output_disable_delay, fixed-output time).
`define PDS_CLK_MHZ      32'h0000_000A
`define PDS_IN_DIS_CLKS  8'h04
`define PDS_Q_DIS_CLKS   8'h08
`define PDS_FIX_OUT_CLKS 8'h08

// Activation time, longest, in ns; the count rounds down.
`define PDS_ACT_TIME_NS  32'h0000_07D0
`define PDS_ACT_CLKS     ((`PDS_ACT_TIME_NS * `PDS_CLK_MHZ) / 32'h0000_03E8)

// Reset and idle levels.
`define PDS_CS_IDLE      4'hF
`define PDS_CKE_RST      2'h0
`define PDS_ODT_RST      2'h0
`define PDS_AC_RST       22'h00_0000
`define PDS_TWO_SEL_MASK 2'h3

`endif

// ### core/pds_pkg.sv
package pds_pkg;

    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_ENTRY  = 6'h02,
        ST_PDOWN  = 6'h04,
        ST_EXIT   = 6'h08,
        ST_CKSTOP = 6'h10,
        ST_WAKE   = 6'h20
    } pds_state_e;

    typedef logic [7:0] pds_count_t;

endpackage

// ### core/pds_timer.sv
`timescale 1ns/1ns
`include "pds_defines.svh"

// Down counter; last is high in the cycle whose edge ends the interval.
module pds_timer
    import pds_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       start,
    input  wire pds_count_t load_val,
    // Status
    output logic            last
);

    pds_count_t count_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_q <= 8'h00;
        end else if (start) begin
            count_q <= load_val;
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end
    end

    assign last = (count_q == 8'h01);

endmodule

// ### sim/pds_ctrl_model.sv
`timescale 1ns/1ns
`include "pds_defines.svh"

// Controller stand-in. Every task drives just after a rising edge; drive, pd_enter and pd_exit return on the edge
// that drives their last values, one edge before the design samples them, and clk_stop and wake on the sampling edge.
module pds_ctrl_model #(
    parameter int CK_OFF = 4,
    parameter int CKEV   = 4,
    parameter int STAB   = 30
) (
    // Clock
    input  wire logic                  clk,
    // Controller outputs
    output logic      [`PDS_CKE_W-1:0] cke,
    output logic      [`PDS_CS_W-1:0]  cs_n,
    output logic      [`PDS_ODT_W-1:0] odt,
    output logic      [`PDS_AC_W-1:0]  ac,
    output logic                       ck_stop
);
    logic floating;

    initial begin
        cke      = 2'h3;
        cs_n     = 4'hF;
        odt      = 2'h0;
        ac       = 22'h00_0000;
        ck_stop  = 1'b0;
        floating = 1'b0;
    end

    // Released address lines wander, so a design that keeps sampling them cannot hold steady.
    always @(posedge clk) begin
        if (floating) begin
            ac <= ~ac;
        end
    end

    // One edge to stop wandering first, so two writers never touch the address bus at one edge.
    task automatic drive(input logic [1:0] k, input logic [3:0] s, input logic [1:0] o, input logic [21:0] a);
        @(posedge clk);
        floating <= 1'b0;
        @(posedge clk);
        cke  <= k;
        cs_n <= s;
        odt  <= o;
        ac   <= a;
    endtask

    task automatic pd_enter(input logic [3:0] s, input logic [21:0] a, input logic flt);
        @(posedge clk);
        cke  <= 2'h0;
        cs_n <= s;
        ac   <= a;
        @(posedge clk);
        cs_n     <= 4'hF;
        floating <= flt;
    endtask

    task automatic pd_exit(input logic [1:0] k, input logic [3:0] s, input logic [3:0] s2, input logic [21:0] a);
        @(posedge clk);
        floating <= 1'b0;
        @(posedge clk);
        cke  <= k;
        cs_n <= s;
        ac   <= a;
        @(posedge clk);
        cs_n <= s2;
        @(posedge clk);
        cs_n <= 4'hF;
    endtask

    // Called only with the memory in self-refresh and the enable power-down in force.
    task automatic clk_stop();
        repeat (CK_OFF) @(posedge clk);
        ck_stop <= 1'b1;
        @(posedge clk);
    endtask

    // The enables were left untouched for far longer than CKEV clocks before waking.
    task automatic wake();
        repeat (CKEV) @(posedge clk);
        floating <= 1'b0;
        cs_n     <= 4'hF;
        cke      <= 2'h0;
        @(posedge clk);
        ck_stop <= 1'b0;
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (STAB) @(posedge clk);
    endtask
endmodule

// ### sim/pds_power_down_seq_tb.sv
`timescale 1ns/1ns
`include "pds_defines.svh"

`define CHK(what, exp, got) \
    n_compared++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("BAD %s expected %0h seen %0h", what, exp, got); \
    end

module pds_power_down_seq_tb;
    import pds_pkg::*;

    logic                  clk;
    logic                  rstn;
    logic                  pd_en;
    logic                  keep;
    logic                  four_sel;
    logic [`PDS_CKE_W-1:0] clock_enable_in;
    logic [`PDS_CS_W-1:0]  chip_select_in_n;
    logic [`PDS_ODT_W-1:0] termination_ctrl_in;
    logic [`PDS_AC_W-1:0]  addr_cmd_in;
    logic                  clocks_stopped;
    logic [`PDS_CKE_W-1:0] clock_enable_out;
    logic [`PDS_CS_W-1:0]  chip_select_out_n;
    logic                  chip_select_oe_n;
    logic [`PDS_ODT_W-1:0] termination_ctrl_out;
    logic                  termination_oe_n;
    logic [`PDS_AC_W-1:0]  address_out;
    logic                  address_oe_n;
    logic                  addr_rx_en;
    logic                  parity_rx_en;
    logic                  termination_rx_en;
    logic                  input_termination_en;
    logic                  pll_run;
    int                    bad_count;
    int                    n_compared;

    pds_ctrl_model ctrl (.clk(clk), .cke(clock_enable_in), .cs_n(chip_select_in_n), .odt(termination_ctrl_in),
                         .ac(addr_cmd_in), .ck_stop(clocks_stopped));

    pds_power_down_seq DUT (
        .clk(clk), .rstn(rstn), .power_down_enable_bit(pd_en), .termination_keep_bit(keep),
        .four_select_mode(four_sel), .clock_enable_in(clock_enable_in), .chip_select_in_n(chip_select_in_n),
        .termination_ctrl_in(termination_ctrl_in), .addr_cmd_in(addr_cmd_in), .clocks_stopped(clocks_stopped),
        .clock_enable_out(clock_enable_out), .chip_select_out_n(chip_select_out_n),
        .chip_select_oe_n(chip_select_oe_n), .termination_ctrl_out(termination_ctrl_out),
        .termination_oe_n(termination_oe_n), .address_out(address_out), .address_oe_n(address_oe_n),
        .addr_rx_en(addr_rx_en), .parity_rx_en(parity_rx_en), .termination_rx_en(termination_rx_en),
        .input_termination_en(input_termination_en), .pll_run(pll_run));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        step(8);
        `CHK("cke_out", 2'h0, clock_enable_out)
        `CHK("cs_out", 4'hF, chip_select_out_n)
        `CHK("addr_oe", 1'b1, address_oe_n)
        rstn <= 1'b1;
        step(1);
        `CHK("addr_oe", 1'b0, address_oe_n)
    endtask

    task automatic t_pass();
        ctrl.drive(2'h3, 4'hE, 2'h1, 22'h15_A5A5);
        step(1);
        `CHK("cs_out", 4'hE, chip_select_out_n)
        `CHK("addr_out", 22'h15_A5A5, address_out)
        ctrl.drive(2'h3, 4'h2, 2'h3, 22'h15_A5A5);
        four_sel <= 1'b0;
        step(1);
        `CHK("cs_two_sel", 4'hE, chip_select_out_n)
        four_sel <= 1'b1;
    endtask

    // Entry with termination switched off, a command riding on the enable drop.
    task automatic t_entry_off();
        ctrl.pd_enter(4'hD, 22'h2C_3C3C, 1'b1);
        step(0);
        `CHK("cke_out", 2'h0, clock_enable_out)
        `CHK("cs_out", 4'hD, chip_select_out_n)
        `CHK("addr_out", 22'h2C_3C3C, address_out)
        step(3);
        `CHK("addr_rx", 1'b1, addr_rx_en)
        step(1);
        `CHK("addr_rx", 1'b0, addr_rx_en)
        `CHK("parity_rx", 1'b1, parity_rx_en)
        `CHK("term_rx", 1'b0, termination_rx_en)
        `CHK("ibt", 1'b0, input_termination_en)
        `CHK("odt_out", 2'h0, termination_ctrl_out)
        step(1);
        `CHK("parity_rx", 1'b0, parity_rx_en)
        step(2);
        `CHK("addr_oe", 1'b0, address_oe_n)
        step(1);
        `CHK("addr_oe", 1'b1, address_oe_n)
        `CHK("cs_oe", 1'b1, chip_select_oe_n)
        `CHK("term_oe", 1'b0, termination_oe_n)
        `CHK("pll", 1'b1, pll_run)
    endtask

    task automatic t_exit_off();
        fork
            ctrl.pd_exit(2'h1, 4'hF, 4'hB, 22'h11_1111);
            begin
                step(3);
                `CHK("cke_out", 2'h1, clock_enable_out)
                `CHK("cs_out", 4'hF, chip_select_out_n)
                `CHK("odt_out", 2'h0, termination_ctrl_out)
                `CHK("addr_out", 22'h2C_3C3C, address_out)
            end
        join
        step(0);
        `CHK("cs_out", 4'hB, chip_select_out_n)
        ctrl.drive(2'h3, 4'hF, 2'h3, 22'h11_1111);
        step(4);
        `CHK("addr_held", 22'h2C_3C3C, address_out)
        `CHK("odt_out", 2'h0, termination_ctrl_out)
        step(3);
        `CHK("addr_out", 22'h11_1111, address_out)
        `CHK("odt_out", 2'h3, termination_ctrl_out)
    endtask

    // Termination kept on: its receivers stay and its outputs keep following.
    task automatic t_keep_on();
        keep <= 1'b1;
        ctrl.pd_enter(4'hF, 22'h03_3333, 1'b0);
        step(4);
        `CHK("addr_rx", 1'b0, addr_rx_en)
        `CHK("term_rx", 1'b1, termination_rx_en)
        `CHK("ibt", 1'b1, input_termination_en)
        ctrl.drive(2'h0, 4'hF, 2'h2, 22'h03_3333);
        step(1);
        `CHK("odt_out", 2'h2, termination_ctrl_out)
        step(1);
        `CHK("addr_oe", 1'b1, address_oe_n)
        `CHK("term_oe", 1'b0, termination_oe_n)
        fork
            ctrl.pd_exit(2'h2, 4'h7, 4'hF, 22'h04_4444);
            begin
                step(3);
                `CHK("cke_out", 2'h2, clock_enable_out)
                `CHK("cs_out", 4'hF, chip_select_out_n)
                `CHK("odt_out", 2'h2, termination_ctrl_out)
            end
        join
        step(9);
        keep <= 1'b0;
    endtask

    task automatic t_refuse();
        ctrl.drive(2'h3, 4'hF, 2'h0, 22'h05_5555);
        pd_en <= 1'b0;
        ctrl.pd_enter(4'hF, 22'h05_5555, 1'b0);
        step(8);
        `CHK("addr_rx", 1'b1, addr_rx_en)
        `CHK("addr_oe", 1'b0, address_oe_n)
        ctrl.drive(2'h3, 4'hF, 2'h0, 22'h05_5555);
        pd_en <= 1'b1;
        step(2);
    endtask

    task automatic t_clock_stop();
        int n;
        ctrl.pd_enter(4'hF, 22'h06_6666, 1'b1);
        ctrl.clk_stop();
        step(0);
        `CHK("pll", 1'b0, pll_run)
        `CHK("cke_out", 2'h0, clock_enable_out)
        `CHK("oe_all", 3'h7, {address_oe_n, chip_select_oe_n, termination_oe_n})
        ctrl.wake();
        for (n = 1; n <= 40; n++) begin
            step(1);
            if (address_oe_n === 1'b0) break;
        end
        if (n > 40) begin
            bad_count++;
            conclude();
        end
        `CHK("wake_clks", 1'b1, n >= `PDS_ACT_CLKS && n <= `PDS_ACT_CLKS + 1)
        `CHK("pll", 1'b1, pll_run)
        ctrl.settle();
    endtask

    // Reset in mid power-down returns everything to normal.
    task automatic t_reset_mid();
        ctrl.drive(2'h3, 4'hF, 2'h0, 22'h07_7777);
        ctrl.pd_enter(4'hF, 22'h07_7777, 1'b1);
        step(5);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        step(0);
        `CHK("addr_rx", 1'b1, addr_rx_en)
        `CHK("parity_rx", 1'b1, parity_rx_en)
        step(1);
        `CHK("addr_oe", 1'b0, address_oe_n)
        `CHK("ibt", 1'b1, input_termination_en)
    endtask

    initial begin
        rstn       = 1'b0;
        pd_en      = 1'b1;
        keep       = 1'b0;
        four_sel   = 1'b1;
        bad_count  = 0;
        n_compared = 0;
        t_reset();
        t_pass();
        t_entry_off();
        t_exit_off();
        t_keep_on();
        t_refuse();
        t_clock_stop();
        t_reset_mid();
        conclude();
    end
endmodule
